// ---- rtl/rpms_aux_clk_gen.sv ----
// Divider that makes the low-frequency auxiliary host clock
`timescale 1ns/10ps
module rpms_aux_clk_gen
  import rpms_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control and clock out
  input  wire logic en_i,
  output logic      aux_clk_o
);

  localparam logic [AUX_DIV_W-1:0] HALF_LAST = AUX_DIV_W'(AUX_HALF_CYC - 1);

  logic [AUX_DIV_W-1:0] div_r;

  // Held low while off so the output never shows a runt pulse on enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r     <= '0;
      aux_clk_o <= 1'b0;
    end else if (!en_i) begin
      div_r     <= '0;
      aux_clk_o <= 1'b0;
    end else if (div_r == HALF_LAST) begin
      div_r     <= '0;
      aux_clk_o <= !aux_clk_o;
    end else begin
      div_r     <= div_r + 1'b1;
    end
  end

endmodule // rpms_aux_clk_gen

// ---- rtl/rpms_pkg.sv ----
// Shared constants and types of the reader power mode sequencer
package rpms_pkg;

  // Clock and time base
  localparam int unsigned REF_CLK_HZ         = 40000000;
  localparam int unsigned CLK_PERIOD_NS      = 25;

  // Times in their own units and derived cycle counts
  localparam int unsigned AUX_HOLD_TIME_NS   = 100000;
  localparam int unsigned AUX_HOLD_CYC       = AUX_HOLD_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned MODE1_RECOVER_NS   = 25000;
  localparam int unsigned MODE1_RECOVER_CYC  = MODE1_RECOVER_NS / CLK_PERIOD_NS;
  localparam int unsigned STBY_RECOVER_NS    = 100000;
  localparam int unsigned STBY_RECOVER_CYC   = STBY_RECOVER_NS / CLK_PERIOD_NS;
  localparam int unsigned STBY_ENTRY_NS      = 4800000;
  localparam int unsigned STBY_ENTRY_CYC     = STBY_ENTRY_NS / CLK_PERIOD_NS;
  localparam int unsigned AUX_CLK_HZ         = 60000;
  localparam int unsigned AUX_HALF_CYC       = REF_CLK_HZ / (2 * AUX_CLK_HZ);

  // Counter widths
  localparam int unsigned TMR_W              = 18;
  localparam int unsigned AUX_DIV_W          = 9;

  // Register byte addresses
  localparam logic [31:0] CTRL_ADDR          = 32'h0000_0000;
  localparam logic [31:0] STAT_ADDR          = 32'h0000_0004;

  // Chip status control fields and reset value
  localparam int unsigned CTRL_SUPPLY5_BIT   = 0;
  localparam int unsigned CTRL_RX_BIT        = 1;
  localparam int unsigned CTRL_HALF_BIT      = 4;
  localparam int unsigned CTRL_RF_BIT        = 5;
  localparam int unsigned CTRL_STANDBY_BIT   = 7;
  localparam logic [7:0]  CTRL_RESET         = 8'h01;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB     = 0;
  localparam int unsigned STAT_HF_BIT        = 3;
  localparam int unsigned STAT_STBY_OK_BIT   = 4;
  localparam int unsigned STAT_MODE_OK_BIT   = 5;
  localparam int unsigned STAT_AUXWAKE_BIT   = 6;
  localparam int unsigned STAT_TX_BIT        = 7;
  localparam int unsigned STAT_RX_BIT        = 8;
  localparam int unsigned STAT_HALF_BIT      = 9;

  // AHB-Lite codes
  localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
  localparam logic        HRESP_OKAY         = 1'h0;

  typedef enum logic [2:0] {
    ST_PWR_DOWN = 3'h0,
    ST_SLEEP    = 3'h1,
    ST_START    = 3'h2,
    ST_AUX_HOLD = 3'h3,
    ST_ACTIVE   = 3'h4
  } rpms_state_type;

  typedef struct packed {
    logic reg_en;
    logic osc_en;
    logic host_supply;
    logic aux_clk_en;
    logic hf_sel;
    logic tx_en;
    logic tx_half;
    logic rx_en;
  } rpms_pwr_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } rpms_ahb_ap_type;

endpackage

// ---- rtl/rpms_timer.sv ----
// Loadable down-counter with busy level and done pulse
`timescale 1ns/10ps
module rpms_timer
  import rpms_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [TMR_W-1:0] load_val_i,
  // Status
  output logic                  busy_o,
  output logic                  done_o
);

  logic [TMR_W-1:0] count_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (load_i) begin
      count_r <= load_val_i;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= !load_i && (count_r == {{(TMR_W-1){1'b0}}, 1'b1});
    end
  end

  assign busy_o = (count_r != '0);

endmodule // rpms_timer

// ---- rtl/rpms_top.sv ----
// Power state sequencer of the reader front end with its AHB-Lite registers
// Summary of operation
// - Main low, aux high: sleep, host supply on, 60 kHz clock, rest off.
// - Both wake pins low: full power-down, supply, clocks, TX and RX off.
// - Aux pin rising edge starts regulators and oscillator like main high.
// - Main pin high, or confirmed aux wake, enables regulators and oscillator.
// - After supplies and oscillator settle, host clock moves to crystal clock.
// - After aux wake, main low 100 us past switch-over returns to power-down.
// - With main pin high, control register at 0x00 selects the power mode.
// - Bit 7 selects standby; return to full operation within 100 us.
// - Standby: TX, RX off, crystal clock and supply on, entry takes 4.8 ms.
// - Bits 5 and 1 clear: RF off, clock runs, recovery within 25 us.
// - Bit 1 set, bit 5 clear: receiver only, transmitter off.
// - Bit 5 set: whole RF on; value 0x21 full power, 0x31 half power.
// - Modes 3 and 4 are the normal transmit and receive states.
// - Bit 0 selects supply: set is 5 V system (default), clear is 3 V.
`timescale 1ns/10ps
module rpms_top
  import rpms_pkg::*;
#(
  parameter int unsigned STBY_ENTRY_CYCLES = STBY_ENTRY_CYC
)
(
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Wake pins and analog handshakes
  input  wire logic        MAIN_WAKE_I,
  input  wire logic        AUXILIARY_WAKE_PIN_I,
  input  wire logic        SUPPLY_OK_I,
  input  wire logic        OSC_STABLE_I,
  input  wire logic        HF_CLK_I,
  // Power and clock controls
  output logic             REG_EN_O,
  output logic             OSC_EN_O,
  output logic             HOST_SUPPLY_EN_O,
  output logic             TX_EN_O,
  output logic             TX_HALF_O,
  output logic             RX_EN_O,
  output logic             SUPPLY_5V_O,
  output logic             HOST_CLK_HF_O,
  output logic             HOST_CLOCK_OUTPUT_O,
  output logic             READY_O
);

  // Mode decode of the control byte while the main pin is high
  function automatic rpms_pwr_type rpms_mode_decode(input logic [7:0] ctrl);
    rpms_pwr_type p;
    p             = '0;
    p.reg_en      = 1'b1;
    p.osc_en      = 1'b1;
    p.host_supply = 1'b1;
    p.hf_sel      = 1'b1;
    if (ctrl[CTRL_STANDBY_BIT]) begin
      p.tx_en = 1'b0;
      p.rx_en = 1'b0;
    end else if (ctrl[CTRL_RF_BIT]) begin
      p.tx_en   = 1'b1;
      p.rx_en   = 1'b1;
      p.tx_half = ctrl[CTRL_HALF_BIT];
    end else if (ctrl[CTRL_RX_BIT]) begin
      p.rx_en = 1'b1;
    end
    return p;
  endfunction

  rpms_state_type  state_r;
  rpms_state_type  state_nxt;
  rpms_pwr_type    pwr_r;
  rpms_pwr_type    pwr_nxt;
  rpms_ahb_ap_type ap_r;
  logic [7:0]      ctrl_r;
  logic            aux_prev_r;
  logic            aux_rise;
  logic            aux_wake_r;
  logic            pulse_exit_r;
  logic            hf_ready;
  logic            ctrl_wr;
  logic [7:0]      ctrl_view;
  logic [31:0]     rd_mux;
  logic            aux_clk;
  logic            hold_load;
  logic            hold_done;
  logic            entry_load;
  logic            entry_busy;
  logic            rec_load;
  logic            rec_busy;
  logic [TMR_W-1:0] rec_val;
  logic            entered_active;

  assign aux_rise = AUXILIARY_WAKE_PIN_I && !aux_prev_r;
  assign hf_ready = SUPPLY_OK_I && OSC_STABLE_I;

  // Edge detector on the aux pin; inputs are synchronous to the clock
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aux_prev_r <= 1'b0;
    end else begin
      aux_prev_r <= AUXILIARY_WAKE_PIN_I;
    end
  end

  // Aux wake marker; a new edge wins over the clear
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aux_wake_r <= 1'b0;
    end else if (aux_rise && (state_r == ST_PWR_DOWN)) begin
      aux_wake_r <= 1'b1;
    end else if ((state_nxt == ST_ACTIVE) || (state_nxt == ST_PWR_DOWN)) begin
      aux_wake_r <= 1'b0;
    end
  end

  // A timed-out pulse wake must not drop into sleep while the pin is still high
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pulse_exit_r <= 1'b0;
    end else if (hold_done && (state_r == ST_AUX_HOLD)) begin
      pulse_exit_r <= 1'b1;
    end else if (!AUXILIARY_WAKE_PIN_I) begin
      pulse_exit_r <= 1'b0;
    end
  end

  // Next power state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_PWR_DOWN: begin
        if (MAIN_WAKE_I || aux_rise) begin
          state_nxt = ST_START;
        end else if (AUXILIARY_WAKE_PIN_I && !pulse_exit_r) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (MAIN_WAKE_I) begin
          state_nxt = ST_START;
        end else if (!AUXILIARY_WAKE_PIN_I) begin
          state_nxt = ST_PWR_DOWN;
        end
      end
      ST_START: begin
        if (!MAIN_WAKE_I && !aux_wake_r) begin
          state_nxt = AUXILIARY_WAKE_PIN_I ? ST_SLEEP : ST_PWR_DOWN;
        end else if (hf_ready) begin
          state_nxt = MAIN_WAKE_I ? ST_ACTIVE : ST_AUX_HOLD;
        end
      end
      ST_AUX_HOLD: begin
        if (MAIN_WAKE_I) begin
          state_nxt = ST_ACTIVE;
        end else if (hold_done) begin
          state_nxt = ST_PWR_DOWN;
        end
      end
      ST_ACTIVE: begin
        if (!MAIN_WAKE_I) begin
          state_nxt = AUXILIARY_WAKE_PIN_I ? ST_SLEEP : ST_PWR_DOWN;
        end
      end
      default: state_nxt = ST_PWR_DOWN;
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= ST_PWR_DOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power controls follow the next state so they change with the state itself
  always_comb begin
    pwr_nxt = '0;
    case (state_nxt)
      ST_PWR_DOWN: pwr_nxt = '0;
      ST_SLEEP: begin
        pwr_nxt.host_supply = 1'b1;
        pwr_nxt.aux_clk_en  = 1'b1;
      end
      ST_START: begin
        pwr_nxt.reg_en      = 1'b1;
        pwr_nxt.osc_en      = 1'b1;
        pwr_nxt.host_supply = 1'b1;
        pwr_nxt.aux_clk_en  = 1'b1;
      end
      ST_AUX_HOLD: begin
        pwr_nxt.reg_en      = 1'b1;
        pwr_nxt.osc_en      = 1'b1;
        pwr_nxt.host_supply = 1'b1;
        pwr_nxt.hf_sel      = 1'b1;
      end
      ST_ACTIVE: pwr_nxt = rpms_mode_decode(ctrl_view);
      default:   pwr_nxt = '0;
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pwr_r <= '0;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Host clock: sampled crystal clock or divided auxiliary clock
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HOST_CLOCK_OUTPUT_O <= 1'b0;
    end else if (pwr_r.hf_sel) begin
      HOST_CLOCK_OUTPUT_O <= HF_CLK_I;
    end else begin
      HOST_CLOCK_OUTPUT_O <= aux_clk && pwr_r.aux_clk_en;
    end
  end

  rpms_aux_clk_gen u_aux_clk (
    .clk_i     (REF_CLK_I),
    .rst_i     (RST_I),
    .en_i      (pwr_nxt.aux_clk_en),
    .aux_clk_o (aux_clk)
  );

  // Pulse-wake window opens at the clock switch-over
  assign hold_load = (state_r == ST_START) && (state_nxt == ST_AUX_HOLD);

  rpms_timer u_hold_tmr (
    .clk_i      (REF_CLK_I),
    .rst_i      (RST_I),
    .load_i     (hold_load),
    .load_val_i (TMR_W'(AUX_HOLD_CYC)),
    .busy_o     (),
    .done_o     (hold_done)
  );

  // Standby entry time runs from the bit going high while active
  assign entered_active = (state_nxt == ST_ACTIVE) && (state_r != ST_ACTIVE);
  assign entry_load     = (state_nxt == ST_ACTIVE) && ctrl_view[CTRL_STANDBY_BIT] &&
                          (!ctrl_r[CTRL_STANDBY_BIT] || entered_active);

  rpms_timer u_entry_tmr (
    .clk_i      (REF_CLK_I),
    .rst_i      (RST_I),
    .load_i     (entry_load),
    .load_val_i (TMR_W'(STBY_ENTRY_CYCLES)),
    .busy_o     (entry_busy),
    .done_o     ()
  );

  // Recovery window when leaving standby or mode 1 for a higher mode
  always_comb begin
    rec_load = 1'b0;
    rec_val  = TMR_W'(MODE1_RECOVER_CYC);
    if ((state_r == ST_ACTIVE) && ctrl_wr) begin
      if (ctrl_r[CTRL_STANDBY_BIT] && !ctrl_view[CTRL_STANDBY_BIT]) begin
        rec_load = 1'b1;
        rec_val  = TMR_W'(STBY_RECOVER_CYC);
      end else if (!ctrl_r[CTRL_STANDBY_BIT] && !ctrl_r[CTRL_RF_BIT] &&
                   !ctrl_r[CTRL_RX_BIT] &&
                   (ctrl_view[CTRL_RF_BIT] || ctrl_view[CTRL_RX_BIT])) begin
        rec_load = 1'b1;
      end
    end
  end

  rpms_timer u_rec_tmr (
    .clk_i      (REF_CLK_I),
    .rst_i      (RST_I),
    .load_i     (rec_load),
    .load_val_i (rec_val),
    .busy_o     (rec_busy),
    .done_o     ()
  );

  // AHB-Lite address phase capture; zero wait states, so hready is always high
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ap_r <= '0;
    end else if (HREADY_I) begin
      ap_r.valid <= HSEL_I && HTRANS_I[1];
      ap_r.write <= HWRITE_I;
      ap_r.addr  <= HADDR_I;
    end
  end

  assign ctrl_wr   = ap_r.valid && ap_r.write && ({ap_r.addr[31:2], 2'h0} == CTRL_ADDR);
  // Forward write data so a read right behind a write sees the new value
  assign ctrl_view = ctrl_wr ? HWDATA_I[7:0] : ctrl_r;

  // Writes land in the data phase; only the low byte holds state
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_r <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_r <= HWDATA_I[7:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case ({HADDR_I[31:2], 2'h0})
      CTRL_ADDR: rd_mux[7:0] = ctrl_view;
      STAT_ADDR: begin
        rd_mux[STAT_STATE_LSB +: 3] = state_r;
        rd_mux[STAT_HF_BIT]         = pwr_r.hf_sel;
        rd_mux[STAT_STBY_OK_BIT]    = pwr_r.hf_sel && ctrl_r[CTRL_STANDBY_BIT] &&
                                      !entry_busy && (state_r == ST_ACTIVE);
        rd_mux[STAT_MODE_OK_BIT]    = (state_r == ST_ACTIVE) && !rec_busy;
        rd_mux[STAT_AUXWAKE_BIT]    = aux_wake_r;
        rd_mux[STAT_TX_BIT]         = pwr_r.tx_en;
        rd_mux[STAT_RX_BIT]         = pwr_r.rx_en;
        rd_mux[STAT_HALF_BIT]       = pwr_r.tx_half;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase edge for the data phase
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      HRDATA_O <= rd_mux;
    end
  end

  // Supply selection, ready flag and the fixed bus answer: no wait states, always OKAY
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= HRESP_OKAY;
      SUPPLY_5V_O <= 1'b1;
      READY_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= HRESP_OKAY;
      SUPPLY_5V_O <= ctrl_view[CTRL_SUPPLY5_BIT];
      READY_O     <= pwr_nxt.hf_sel;
    end
  end

  // Power outputs straight from the power register
  assign REG_EN_O         = pwr_r.reg_en;
  assign OSC_EN_O         = pwr_r.osc_en;
  assign HOST_SUPPLY_EN_O = pwr_r.host_supply;
  assign TX_EN_O          = pwr_r.tx_en;
  assign TX_HALF_O        = pwr_r.tx_half;
  assign RX_EN_O          = pwr_r.rx_en;
  assign HOST_CLK_HF_O    = pwr_r.hf_sel;

endmodule // rpms_top

// ---- sim/rpms_chk.sv ----
// Concurrent checks on the ports of the power mode sequencer
`timescale 1ns/10ps
module rpms_chk
  import rpms_pkg::*;
(
  // Clock and reset
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  // Bus
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic        HREADY_I,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  // Wake and power
  input wire logic        MAIN_WAKE_I,
  input wire logic        AUXILIARY_WAKE_PIN_I,
  input wire logic        SUPPLY_OK_I,
  input wire logic        OSC_STABLE_I,
  input wire logic        REG_EN_O,
  input wire logic        OSC_EN_O,
  input wire logic        HOST_SUPPLY_EN_O,
  input wire logic        TX_EN_O,
  input wire logic        TX_HALF_O,
  input wire logic        RX_EN_O,
  input wire logic        SUPPLY_5V_O,
  input wire logic        HOST_CLK_HF_O,
  input wire logic        READY_O
);
  logic [12:0] hold_cnt_r;
  logic        wr_ctrl_r;
  logic        sup_exp_r;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  // Cycles on the crystal clock with the main pin low; saturates so it never wraps
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hold_cnt_r <= 13'h0;
    end else if (!HOST_CLK_HF_O || MAIN_WAKE_I) begin
      hold_cnt_r <= 13'h0;
    end else if (hold_cnt_r != 13'h1FFF) begin
      hold_cnt_r <= hold_cnt_r + 13'h1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_ctrl_r <= 1'b0;
    end else begin
      wr_ctrl_r <= HREADY_I && HSEL_I && HTRANS_I[1] && HWRITE_I && (HADDR_I[31:2] == 30'h0);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sup_exp_r <= 1'b1;
    end else if (wr_ctrl_r) begin
      sup_exp_r <= HWDATA_I[0];
    end
  end

  sequence aux_wake_s;
    !MAIN_WAKE_I && $rose(AUXILIARY_WAKE_PIN_I) && !REG_EN_O;
  endsequence
  sequence powered_s;
    REG_EN_O && OSC_EN_O && HOST_SUPPLY_EN_O;
  endsequence

  main_wake_a: assert property (MAIN_WAKE_I |=> powered_s)
    else $error("main wake left supplies off");
  aux_wake_a: assert property (aux_wake_s |=> powered_s)
    else $error("aux rise left supplies off");
  hf_power_a: assert property (HOST_CLK_HF_O |-> READY_O ##0 powered_s)
    else $error("crystal clock without power or ready");
  hf_settle_a: assert property ($rose(HOST_CLK_HF_O) |-> $past(SUPPLY_OK_I && OSC_STABLE_I))
    else $error("clock switched before settling");
  rf_gate_a: assert property (!MAIN_WAKE_I |=> !TX_EN_O && !RX_EN_O)
    else $error("rf on with main pin low");
  half_tx_a: assert property (TX_HALF_O |-> TX_EN_O)
    else $error("half power without transmitter");
  tx_rx_a: assert property (TX_EN_O |-> RX_EN_O && HOST_CLK_HF_O)
    else $error("transmitter without receiver or clock");
  hold_max_a: assert property (hold_cnt_r <= 13'hFAA)
    else $error("aux hold outlived its window");
  hold_min_a: assert property ($fell(HOST_CLK_HF_O) |-> hold_cnt_r <= 13'h2 || hold_cnt_r >= 13'hF96)
    else $error("aux hold ended early");
  bus_okay_a: assert property (HSEL_I && HTRANS_I[1] |=> HREADYOUT_O && HRESP_O == HRESP_OKAY)
    else $error("bus answer not ready okay");
  supply_bit_a: assert property (wr_ctrl_r |=> ##[0:1] SUPPLY_5V_O == sup_exp_r)
    else $error("supply select not following write");
endmodule // rpms_chk

// ---- sim/rpms_host_model.sv ----
// Host and analog side model: wake pin sequencing and settle handshakes
`timescale 1ns/10ps
module rpms_host_model
  import rpms_pkg::*;
#(
  parameter int unsigned GAP_CYC = 40
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Requests from the bench
  input  wire logic       main_req_i,
  input  wire logic       aux_req_i,
  input  wire logic [7:0] settle_i,
  // Device controls seen
  input  wire logic       reg_en_i,
  input  wire logic       osc_en_i,
  // Pins and handshakes
  output logic            main_o,
  output logic            aux_o,
  output logic            supply_ok_o,
  output logic            osc_stable_o,
  output logic            hf_clk_o
);
  logic [15:0] gap_r;
  logic [7:0]  reg_cnt_r;
  logic [7:0]  osc_cnt_r;

  // One pin moves at a time, then a quiet gap; the gap is scaled down from 5 ms to keep runs short
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_o <= 1'b0;
      aux_o  <= 1'b0;
      gap_r  <= 16'h0;
    end else if (gap_r != 16'h0) begin
      gap_r <= gap_r - 16'h1;
    end else if (aux_req_i != aux_o) begin
      aux_o <= aux_req_i;
      gap_r <= GAP_CYC[15:0];
    end else if (main_req_i != main_o) begin
      main_o <= main_req_i;
      gap_r  <= GAP_CYC[15:0];
    end
  end

  // Settle counts restart whenever the enable drops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_cnt_r <= 8'h0;
      osc_cnt_r <= 8'h0;
      hf_clk_o  <= 1'b0;
    end else begin
      reg_cnt_r <= !reg_en_i ? 8'h0 : (reg_cnt_r != settle_i) ? reg_cnt_r + 8'h1 : reg_cnt_r;
      osc_cnt_r <= !osc_en_i ? 8'h0 : (osc_cnt_r != settle_i) ? osc_cnt_r + 8'h1 : osc_cnt_r;
      hf_clk_o  <= osc_stable_o && !hf_clk_o;
    end
  end

  assign supply_ok_o  = reg_en_i && (reg_cnt_r == settle_i);
  assign osc_stable_o = osc_en_i && (osc_cnt_r == settle_i);
endmodule // rpms_host_model

// ---- sim/rpms_test.sv ----
// Self-checking bench of the power mode sequencer
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); err_count++; end end
module rpms_test
  import rpms_pkg::*;
;
  localparam int unsigned STBY_CYC = 20;
  localparam int unsigned GAP      = 40;
  logic        REF_CLK_I = 1'b0;
  logic        RST_I     = 1'b0;
  logic        HSEL_I    = 1'b0;
  logic [31:0] HADDR_I   = 32'h0;
  logic [1:0]  HTRANS_I  = 2'h0;
  logic        HWRITE_I  = 1'b0;
  logic [31:0] HWDATA_I  = 32'h0;
  logic        HREADY_I, HREADYOUT_O, HRESP_O, MAIN_WAKE_I, AUXILIARY_WAKE_PIN_I;
  logic        SUPPLY_OK_I, OSC_STABLE_I, HF_CLK_I, REG_EN_O, OSC_EN_O, HOST_SUPPLY_EN_O;
  logic        TX_EN_O, TX_HALF_O, RX_EN_O, SUPPLY_5V_O, HOST_CLK_HF_O, HOST_CLOCK_OUTPUT_O, READY_O;
  logic [31:0] HRDATA_O, rd;
  logic        main_req  = 1'b0;
  logic        aux_req   = 1'b0;
  logic [7:0]  settle    = 8'h3C;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;

  always #12.5 REF_CLK_I = ~REF_CLK_I;
  assign HREADY_I = HREADYOUT_O;

  rpms_top #(.STBY_ENTRY_CYCLES(STBY_CYC)) u_dut (
    .REF_CLK_I, .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I(3'h2), .HWDATA_I,
    .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .MAIN_WAKE_I, .AUXILIARY_WAKE_PIN_I,
    .SUPPLY_OK_I, .OSC_STABLE_I, .HF_CLK_I, .REG_EN_O, .OSC_EN_O, .HOST_SUPPLY_EN_O, .TX_EN_O,
    .TX_HALF_O, .RX_EN_O, .SUPPLY_5V_O, .HOST_CLK_HF_O, .HOST_CLOCK_OUTPUT_O, .READY_O);

  rpms_host_model #(.GAP_CYC(GAP)) u_host (
    .clk_i(REF_CLK_I), .rst_i(RST_I), .main_req_i(main_req), .aux_req_i(aux_req),
    .settle_i(settle), .reg_en_i(REG_EN_O), .osc_en_i(OSC_EN_O), .main_o(MAIN_WAKE_I),
    .aux_o(AUXILIARY_WAKE_PIN_I), .supply_ok_o(SUPPLY_OK_I), .osc_stable_o(OSC_STABLE_I),
    .hf_clk_o(HF_CLK_I));

  task automatic cyc(input int k);
    repeat (k) @(negedge REF_CLK_I);
  endtask

  task automatic wait_on(ref logic s, input logic lvl);
    int k;
    k = 0;
    while (s !== lvl && k < 1000) begin
      cyc(1);
      k++;
    end
    if (s !== lvl) begin
      $display("wrong value wait expected %0h seen %0h", lvl, s);
      err_count++;
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge REF_CLK_I);
    HSEL_I   <= 1'b1;
    HTRANS_I <= HTRANS_NONSEQ;
    HADDR_I  <= addr;
    HWRITE_I <= wr;
    do @(posedge REF_CLK_I); while (HREADYOUT_O !== 1'b1);
    HSEL_I   <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= wd;
    do @(posedge REF_CLK_I); while (HREADYOUT_O !== 1'b1);
    rd = HRDATA_O;
  endtask

  task automatic count_clk;
    n = 0;
    for (int i = 0; i < 2 * AUX_HALF_CYC; i++) begin
      cyc(1);
      n += HOST_CLOCK_OUTPUT_O;
    end
  endtask

  task automatic t_wake;
    `CHK("off", 3'h0, {REG_EN_O, OSC_EN_O, HOST_SUPPLY_EN_O})
    `CHK("supply5", 1'b1, SUPPLY_5V_O)
    @(posedge REF_CLK_I);
    main_req <= 1'b1;
    wait_on(READY_O, 1'b1);
    `CHK("powered", 3'h7, {REG_EN_O, OSC_EN_O, HOST_SUPPLY_EN_O})
    `CHK("hf", 2'h3, {HOST_CLK_HF_O, SUPPLY_OK_I & OSC_STABLE_I})
    ahb(1'b0, CTRL_ADDR, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    cyc(1);
    n = HOST_CLOCK_OUTPUT_O;
    cyc(1);
    `CHK("hf_clk", n == 0, HOST_CLOCK_OUTPUT_O)
  endtask

  task automatic t_modes;
    logic [7:0] tbl [10] = '{8'h21, 8'h31, 8'h20, 8'h30, 8'h03, 8'h02, 8'h01, 8'h00, 8'h81, 8'h80};
    logic [7:0] v;
    for (int i = 0; i < 10; i++) begin
      v = tbl[i];
      ahb(1'b1, CTRL_ADDR, {24'h0, v});
      cyc(2);
      `CHK("tx", v[5] & ~v[7], TX_EN_O)
      `CHK("rx", (v[5] | v[1]) & ~v[7], RX_EN_O)
      `CHK("half", v[5] & v[4] & ~v[7], TX_HALF_O)
      `CHK("supply5", v[0], SUPPLY_5V_O)
      `CHK("hf", 1'b1, HOST_CLK_HF_O)
      ahb(1'b0, CTRL_ADDR, 32'h0);
      `CHK("ctrl", {24'h0, v}, rd)
    end
    ahb(1'b0, STAT_ADDR, 32'h0);
    `CHK("stby_wait", 1'b0, rd[STAT_STBY_OK_BIT])
    cyc(STBY_CYC + 4);
    ahb(1'b0, STAT_ADDR, 32'h0);
    `CHK("stby", 2'h3, {rd[STAT_STBY_OK_BIT], HOST_SUPPLY_EN_O})
    ahb(1'b1, CTRL_ADDR, 32'h21);
    cyc(2);
    `CHK("stby_out", 1'b1, TX_EN_O)
    ahb(1'b1, CTRL_ADDR, 32'h01);
    ahb(1'b1, CTRL_ADDR, 32'h31);
    cyc(2);
    `CHK("m1_out", 2'h3, {TX_EN_O, TX_HALF_O})
    ahb(1'b0, STAT_ADDR, 32'h0);
    `CHK("mode_busy", 1'b0, rd[STAT_MODE_OK_BIT])
    cyc(1005);
    ahb(1'b0, STAT_ADDR, 32'h0);
    `CHK("mode_ok", 1'b1, rd[STAT_MODE_OK_BIT])
  endtask

  task automatic t_sleep_pd;
    @(posedge REF_CLK_I);
    aux_req  <= 1'b1;
    main_req <= 1'b0;
    wait_on(HOST_CLK_HF_O, 1'b0);
    cyc(3);
    `CHK("sleep", 4'h8, {HOST_SUPPLY_EN_O, HOST_CLK_HF_O, TX_EN_O, RX_EN_O})
    count_clk();
    `CHK("aux_clk", AUX_HALF_CYC, n)
    @(posedge REF_CLK_I);
    aux_req <= 1'b0;
    wait_on(HOST_SUPPLY_EN_O, 1'b0);
    cyc(2);
    `CHK("pd", 3'h0, {REG_EN_O, OSC_EN_O, HOST_CLK_HF_O})
    count_clk();
    `CHK("pd_clk", 0, n)
  endtask

  task automatic t_aux;
    @(posedge REF_CLK_I);
    settle  <= 8'h02;
    aux_req <= 1'b1;
    wait_on(AUXILIARY_WAKE_PIN_I, 1'b1);
    cyc(2);
    `CHK("aux_pwr", 4'hE, {REG_EN_O, OSC_EN_O, HOST_SUPPLY_EN_O, TX_EN_O})
    wait_on(HOST_CLK_HF_O, 1'b1);
    cyc(3990);
    `CHK("hold", 1'b1, HOST_CLK_HF_O)
    cyc(30);
    `CHK("hold_end", 2'h0, {HOST_CLK_HF_O, REG_EN_O})
    @(posedge REF_CLK_I);
    aux_req <= 1'b0;
    cyc(GAP + 4);
    @(posedge REF_CLK_I);
    aux_req <= 1'b1;
    wait_on(HOST_CLK_HF_O, 1'b1);
    @(posedge REF_CLK_I);
    main_req <= 1'b1;
    cyc(4100);
    `CHK("kept", 1'b1, READY_O)
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is about 11k cycles; the limit leaves ample margin
  initial begin
    repeat (40000) @(posedge REF_CLK_I);
    err_count++;
    wrap_up();
  end

  initial begin
    RST_I <= 1'b1;
    repeat (6) @(posedge REF_CLK_I);
    RST_I <= 1'b0;
    cyc(1);
    t_wake();
    t_modes();
    t_sleep_pd();
    t_aux();
    wrap_up();
  end
endmodule // rpms_test

bind rpms_top rpms_chk u_chk (
  .REF_CLK_I, .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I, .HREADY_I,
  .HREADYOUT_O, .HRESP_O, .MAIN_WAKE_I, .AUXILIARY_WAKE_PIN_I, .SUPPLY_OK_I, .OSC_STABLE_I,
  .REG_EN_O, .OSC_EN_O, .HOST_SUPPLY_EN_O, .TX_EN_O, .TX_HALF_O, .RX_EN_O, .SUPPLY_5V_O,
  .HOST_CLK_HF_O, .READY_O);
